// ### src/async_serial_unit.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "serial_params.svh"
module async_serial_unit
  import serial_pkg::*;
#(
  parameter int BASE_DIV = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rx_line,
  output logic rx_line_used,
  output logic tx_line,
  output logic tx_line_oe,
  output logic tx_irq,
  output logic rx_irq
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:0] ctrl1_q, ctrl2_q, baud_q, rdata_q, tx_data_q, rx_data_q;
  logic tx_bit8_q, rx_bit8_q, arm_q, txbuf_full_q;
  logic tx_empty_q, tx_done_q, rx_full_q, overrun_q, noise_q, framing_q;
  logic break_q;
  ctrl_s c;
  logic [15:0] div_q;
  logic tick;
  logic [2:0] rx_sync_q;
  logic rx_f_q;

  // Reset leaves through two flops so its release is clean.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Register decode.
  wire wr_c1 = wr && addr == `OFS_CTRL_ONE;
  wire wr_c2 = wr && addr == `OFS_CTRL_TWO;
  wire wr_c3 = wr && addr == `OFS_CTRL_THREE;
  wire wr_br = wr && addr == `OFS_BAUD_RATE;
  wire wr_db = wr && addr == `OFS_DATA_BUF;
  wire rd_db = rd && addr == `OFS_DATA_BUF;
  wire rd_st = rd && (addr == `OFS_STATUS_ONE || addr == `OFS_STATUS_TWO);
  assign c.serial_on = ctrl1_q[`B_SERIAL_ON];
  assign c.invert = ctrl1_q[`B_TX_INVERT];
  assign c.nine = ctrl1_q[`B_NINE_BIT];
  assign c.tx_on = ctrl2_q[`B_TX_ON];
  assign c.rx_on = ctrl2_q[`B_RX_ON];
  assign c.send_break = ctrl2_q[`B_SEND_BREAK];
  assign c.long_break = baud_q[`B_LONG_BREAK];
  wire tx_on_rise = wr_c2 && wdata[`B_TX_ON] && !c.tx_on;
  // Empty and receive flags clear only after a status read armed them.
  wire tx_clr = wr_db && arm_q;
  wire rx_clr = rd_db && arm_q;

  // Oversample tick; the rate field scales a fixed base divider.
  wire [15:0] div_top = 16'((BASE_DIV << baud_q[2:0]) - 1);
  assign tick = div_q == 16'h0000;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 16'h0000;
    else if (ce)
      div_q <= tick ? div_top : div_q - 16'h0001;
  end

  // Line input: three flops, a change counts when the last two agree.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sync_q <= 3'b111;
      rx_f_q <= 1'b1;
    end
    else if (ce)
    begin
      rx_sync_q <= {rx_sync_q[1:0], rx_line};
      if (rx_sync_q[1] == rx_sync_q[2])
        rx_f_q <= rx_sync_q[2];
    end
  end

  // ---- Transmitter ----
  tx_kind_e tx_kind_q, next_kind;
  logic [11:0] tx_sh_q, next_sh;
  logic [3:0] tx_cnt_q, tx_ph_q, next_cnt;
  logic idle_q, last_brk_q, txd_q;
  wire [3:0] char_len = c.nine ? `LEN_LONG : `LEN_SHORT;
  wire tx_busy = tx_kind_q != TX_NONE;
  wire bit_end = tick && tx_ph_q == `TICKS_PER_BIT;
  // Break running into a queued idle ends half a bit early.
  wire cut = tick && tx_ph_q == `RT_HALF_BIT && tx_kind_q == TX_BREAK &&
    !c.send_break && idle_q;
  wire char_end = tx_busy && tx_cnt_q == 4'h1 && (bit_end || cut);
  wire load_slot = tx_busy ? char_end : tick;
  wire load_go = c.serial_on && c.tx_on && load_slot &&
    next_kind != TX_NONE;
  wire load_data = load_go && next_kind == TX_DATA;

  // Next character: break, then queued idle, then the one closing high
  // bit after a break, then buffered data.
  always_comb
  begin
    next_kind = TX_NONE;
    next_sh = 12'hfff;
    next_cnt = char_len;
    if (c.send_break)
    begin
      next_kind = TX_BREAK;
      next_sh = 12'h000;
      next_cnt = char_len + {3'b000, c.long_break};
    end
    else if (idle_q)
      next_kind = TX_IDLE;
    else if (last_brk_q)
    begin
      next_kind = TX_IDLE;
      next_cnt = 4'h1;
    end
    else if (txbuf_full_q)
    begin
      next_kind = TX_DATA;
      // Shifted out LSB first after the start bit.
      next_sh = c.nine ? {2'b11, tx_bit8_q, tx_data_q, 1'b0}
        : {3'b111, tx_data_q, 1'b0};
    end
  end

  // Shift register and bit timing.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_kind_q <= TX_NONE;
      tx_sh_q <= 12'hfff;
      tx_cnt_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end
    else if (ce)
    begin
      if (!c.serial_on)
        tx_kind_q <= TX_NONE;
      else if (load_go)
      begin
        tx_kind_q <= next_kind;
        tx_sh_q <= next_sh;
        tx_cnt_q <= next_cnt;
        tx_ph_q <= 4'h0;
      end
      else if (char_end)
        tx_kind_q <= TX_NONE;
      else if (tx_busy && tick)
      begin
        tx_ph_q <= tx_ph_q + 4'h1;
        if (bit_end)
        begin
          tx_sh_q <= {1'b1, tx_sh_q[11:1]};
          tx_cnt_q <= tx_cnt_q - 4'h1;
        end
      end
    end
  end

  // Idle request (preamble or queued) and the post-break memory.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_q <= 1'b0;
      last_brk_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!c.serial_on)
        idle_q <= 1'b0;
      else if (tx_on_rise)
        idle_q <= 1'b1;
      else if (load_go && next_kind == TX_IDLE)
        idle_q <= 1'b0;
      if (load_go)
        last_brk_q <= next_kind == TX_BREAK;
    end
  end

  // Pin level comes from a flop; idle is high before inversion.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      txd_q <= 1'b1;
    else if (ce)
      txd_q <= (tx_busy ? tx_sh_q[0] : 1'b1) ^ c.invert;
  end
  assign tx_line = txd_q;
  assign tx_line_oe = c.serial_on;
  assign rx_line_used = c.serial_on && c.rx_on;

  // ---- Receiver ----
  rx_state_e rx_st_q;
  logic [1:0] ones_q;
  logic [3:0] rt_q, bit_q;
  logic [2:0] smp_q;
  logic [8:0] rx_sh_q;
  logic zero_q, rnoise_q, stop0_q;
  rx_char_s rch;
  wire rx_en = c.serial_on && c.rx_on;
  wire [2:0] smp_all = {smp_q[1:0], rx_f_q};
  // Majority of the three samples; any disagreement is noise.
  wire maj = (smp_all[0] & smp_all[1]) | (smp_all[0] & smp_all[2]) |
    (smp_all[1] & smp_all[2]);
  wire disagree = !(&smp_all) && (|smp_all);
  wire [3:0] nbits = c.nine ? 4'h9 : 4'h8;
  wire decide = rx_st_q == RX_BITS && tick && rt_q == `RT_SAMPLE_C &&
    bit_q != 4'h0;
  wire at_stop = bit_q == nbits + 4'h1;
  wire at_extra = bit_q == nbits + 4'h2;
  // A zero stop after zero data waits one more bit in long mode.
  wire rx_done = decide && ((at_stop && !(c.long_break && zero_q && !maj))
    || at_extra);
  assign rch.brk = zero_q && (at_extra ? (stop0_q && !maj) : !maj);
  assign rch.framing = at_extra ? stop0_q : !maj;
  assign rch.noise = rnoise_q || disagree;
  assign rch.data = rch.brk ? 8'h00 : (c.nine ? rx_sh_q[7:0] : rx_sh_q[8:1]);
  assign rch.bit8 = rch.brk ? 1'b0 : rx_sh_q[8];

  // Start search, verification and bit sampling.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_q <= RX_HUNT;
      ones_q <= 2'b00;
      rt_q <= 4'h0;
      bit_q <= 4'h0;
      smp_q <= 3'b000;
      rx_sh_q <= 9'h000;
      zero_q <= 1'b1;
      rnoise_q <= 1'b0;
      stop0_q <= 1'b0;
    end
    else if (ce && !rx_en)
    begin
      rx_st_q <= RX_HUNT;
      ones_q <= 2'b00;
    end
    else if (ce && tick)
    begin
      rt_q <= rt_q + 4'h1;
      case (rx_st_q)
        RX_HUNT:
        begin
          rt_q <= 4'h1;
          bit_q <= 4'h0;
          zero_q <= 1'b1;
          if (rx_f_q && ones_q != 2'b11)
            ones_q <= ones_q + 2'b01;
          else if (!rx_f_q && ones_q == 2'b11)
            rx_st_q <= RX_START;
          else if (!rx_f_q)
            ones_q <= 2'b00;
        end
        RX_START:
        begin
          if (rt_q[0] && rt_q != 4'h1)
            smp_q <= smp_all;
          if (rt_q == `RT_VERIFY_END)
          begin
            ones_q <= 2'b00;
            // Verified when at most one of the three samples is high.
            rx_st_q <= maj ? RX_HUNT : RX_BITS;
            rnoise_q <= disagree;
          end
        end
        RX_BITS:
        begin
          if (rt_q == `TICKS_PER_BIT)
            bit_q <= bit_q + 4'h1;
          if (rt_q >= `RT_SAMPLE_A && rt_q <= `RT_SAMPLE_B)
            smp_q <= smp_all;
          if (decide)
          begin
            rnoise_q <= rnoise_q || disagree;
            if (bit_q <= nbits)
            begin
              rx_sh_q <= {maj, rx_sh_q[8:1]};
              zero_q <= zero_q && !maj;
            end
            stop0_q <= !maj;
            if (rx_done)
              rx_st_q <= RX_HUNT;
          end
        end
        default:
          rx_st_q <= RX_HUNT;
      endcase
    end
  end

  // ---- Registers and flags ----
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl1_q <= `RST_CTRL;
      ctrl2_q <= `RST_CTRL;
      baud_q <= `RST_CTRL;
      tx_bit8_q <= 1'b0;
      tx_data_q <= 8'h00;
    end
    else if (ce)
    begin
      if (wr_c1)
        ctrl1_q <= wdata;
      if (wr_c2)
        ctrl2_q <= wdata;
      if (wr_br)
        baud_q <= wdata;
      if (wr_c3)
        tx_bit8_q <= wdata[`B_TX_BIT8];
      if (wr_db)
        tx_data_q <= wdata;
    end
  end

  // Hardware set wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arm_q <= 1'b0;
      txbuf_full_q <= 1'b0;
      tx_empty_q <= 1'b1;
      tx_done_q <= 1'b1;
    end
    else if (ce)
    begin
      arm_q <= rd_st || (arm_q && !wr_db && !rd_db);
      txbuf_full_q <= wr_db || (txbuf_full_q && !load_data);
      tx_empty_q <= load_data || (tx_empty_q && !tx_clr);
      // Done mirrors the shifter state, so a fresh write drops it at once.
      tx_done_q <= !tx_busy && !txbuf_full_q && !idle_q && !wr_db;
    end
  end

  // Receive buffer; an overrun keeps the older character.
  wire rx_take = rx_done && !rx_full_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_full_q <= 1'b0;
      overrun_q <= 1'b0;
      noise_q <= 1'b0;
      framing_q <= 1'b0;
      break_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_bit8_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_full_q <= rx_done || (rx_full_q && !rx_clr);
      overrun_q <= (rx_done && rx_full_q) || (overrun_q && !rx_clr);
      noise_q <= (rx_take && rch.noise) || (noise_q && !rx_clr);
      framing_q <= (rx_take && rch.framing) || (framing_q && !rx_clr);
      break_q <= (rx_take && rch.brk) || (break_q && !rx_clr);
      if (rx_take)
      begin
        rx_data_q <= rch.data;
        rx_bit8_q <= rch.bit8;
      end
    end
  end

  // Read mux; data stand only in the cycle after the strobe.
  wire [7:0] st1 = {tx_empty_q, tx_done_q, rx_full_q, 1'b0, overrun_q,
    noise_q, framing_q, 1'b0};
  wire [7:0] st2 = {6'h00, break_q, rx_st_q != RX_HUNT};
  wire [7:0] c3 = {rx_bit8_q, tx_bit8_q, 6'h00};
  wire [7:0] rd_mux =
    addr == `OFS_CTRL_ONE ? ctrl1_q :
    addr == `OFS_CTRL_TWO ? ctrl2_q :
    addr == `OFS_CTRL_THREE ? c3 :
    addr == `OFS_STATUS_ONE ? st1 :
    addr == `OFS_STATUS_TWO ? st2 :
    addr == `OFS_DATA_BUF ? rx_data_q :
    addr == `OFS_BAUD_RATE ? baud_q : 8'h00;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (ce)
      rdata_q <= rd ? rd_mux : 8'h00;
  end
  assign rdata = rdata_q;

  // Interrupt requests are plain flag and enable products.
  assign tx_irq = (tx_empty_q && ctrl2_q[`B_TX_EMPTY_IE]) ||
    (tx_done_q && ctrl2_q[`B_TX_DONE_IE]);
  assign rx_irq = rx_full_q && ctrl2_q[`B_RX_FULL_IE];

  // Checks.
  pin_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(c.serial_on) |-> !tx_line_oe && !rx_line_used)
    else $error("Pins not released.");
  idle_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !tx_busy |=> tx_line != $past(c.invert))
    else $error("Idle line level wrong.");
  frame_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && load_data |=> !tx_sh_q[0] && tx_sh_q[11] && tx_cnt_q == char_len)
    else $error("Frame bits wrong.");
  empty_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && load_data |=> tx_empty_q && !txbuf_full_q)
    else $error("Empty flag not set.");
  preamble_first_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    load_go && idle_q && !c.send_break |=> tx_kind_q == TX_IDLE)
    else $error("Preamble skipped.");
  break_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_kind_q == TX_BREAK |-> tx_sh_q == 12'h000 || tx_cnt_q != 4'h0)
    else $error("Break not zero.");
  done_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !tx_busy && !txbuf_full_q && !idle_q && !wr_db |=> tx_done_q)
    else $error("Done flag missing.");
  rx_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rx_take |=> rx_full_q && rx_data_q == $past(rch.data))
    else $error("Receive hand-off lost.");
  break_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rx_take && rch.brk |=> framing_q && break_q && !rx_bit8_q
      && rx_data_q == 8'h00)
    else $error("Break effects wrong.");
endmodule

// ### pkg/serial_params.svh
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
// Register offsets.
`define OFS_CTRL_ONE 8'h13
`define OFS_CTRL_TWO 8'h14
`define OFS_CTRL_THREE 8'h15
`define OFS_STATUS_ONE 8'h16
`define OFS_STATUS_TWO 8'h17
`define OFS_DATA_BUF 8'h18
`define OFS_BAUD_RATE 8'h19
// Field positions in ctrl_reg_one.
`define B_SERIAL_ON 6
`define B_TX_INVERT 5
`define B_NINE_BIT 4
// Field positions in ctrl_reg_two.
`define B_TX_EMPTY_IE 7
`define B_TX_DONE_IE 6
`define B_RX_FULL_IE 5
`define B_TX_ON 3
`define B_RX_ON 2
`define B_SEND_BREAK 0
// Field positions in ctrl_reg_three.
`define B_RX_BIT8 7
`define B_TX_BIT8 6
// Field positions in status_reg_one.
`define B_TX_EMPTY 7
`define B_TX_DONE 6
`define B_RX_FULL 5
`define B_OVERRUN 3
`define B_NOISE 2
`define B_FRAMING 1
`define B_PARITY 0
// Field positions in status_reg_two and baud_rate_reg.
`define B_BREAK 1
`define B_RX_BUSY 0
`define B_LONG_BREAK 6
// Reset values.
`define RST_STATUS_ONE 8'hc0
`define RST_CTRL 8'h00
// Oversampling timing, in oversample ticks.
`define TICKS_PER_BIT 4'hf
`define RT_VERIFY_END 4'h7
`define RT_SAMPLE_A 4'h8
`define RT_SAMPLE_B 4'h9
`define RT_SAMPLE_C 4'ha
`define RT_HALF_BIT 4'h7
// Character lengths in bit times.
`define LEN_SHORT 4'ha
`define LEN_LONG 4'hb
`endif

// ### pkg/serial_pkg.sv
package serial_pkg;
  typedef enum logic [1:0]
  {
    TX_NONE = 2'b00,
    TX_IDLE = 2'b01,
    TX_DATA = 2'b10,
    TX_BREAK = 2'b11
  } tx_kind_e;
  typedef enum logic [1:0]
  {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } rx_state_e;
  // Control bits that steer both shifters.
  typedef struct packed {
    logic serial_on;
    logic invert;
    logic nine;
    logic tx_on;
    logic rx_on;
    logic send_break;
    logic long_break;
  } ctrl_s;
  // One received character on its way to the buffer.
  typedef struct packed {
    logic [7:0] data;
    logic bit8;
    logic framing;
    logic noise;
    logic brk;
  } rx_char_s;
endpackage

// ### bench/remote_serial.sv
`timescale 1ns/1ps
module remote_serial
#(
  parameter int BIT_CLKS = 16
)
(
  input wire logic clk,
  input wire logic tx_line,
  input wire logic invert,
  input wire logic nine,
  output logic rx_line
);
  int got[$];
  logic [9:0] sh;

  // The far line idles high between frames, as a pulled-up wire would.
  initial rx_line = 1'b1;

  // Sends a prebuilt frame, start bit first, one level per bit time.
  task automatic send_bits(input logic [11:0] f, input int cnt);
    for (int i = 0; i < cnt; i++)
    begin
      rx_line <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask

  // Decodes frames at mid-bit; a low that is gone by then is a glitch,
  // which keeps polarity switches from posing as start bits.
  initial
  forever
  begin
    @(posedge clk);
    if ((tx_line ^ invert) === 1'b0)
    begin
      repeat (BIT_CLKS / 2) @(posedge clk);
      if ((tx_line ^ invert) === 1'b0)
      begin
        sh = '0;
        for (int i = 0; i <= (nine ? 9 : 8); i++)
        begin
          repeat (BIT_CLKS) @(posedge clk);
          sh[i] = tx_line ^ invert;
        end
        got.push_back(int'(sh));
        while ((tx_line ^ invert) !== 1'b1)
          @(posedge clk);
      end
    end
  end
endmodule

// ### bench/async_serial_tx_rx_core_bench.sv
`timescale 1ns/1ps
`include "serial_params.svh"
module async_serial_tx_rx_core_bench;
  logic clk, reset_n, wr, rd, rx_line, rx_line_used, tx_line, tx_line_oe;
  logic tx_irq, rx_irq, tx_wire, inv, nine;
  logic [7:0] addr, wdata, rdata, v;
  logic [8:0] d9;
  logic [31:0] seed;
  int mismatches, checks, n, exp_q[$];

  async_serial_unit #(.BASE_DIV(1)) i_async_serial_unit (.clk(clk),
    .reset_n(reset_n), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_line(rx_line), .rx_line_used(rx_line_used),
    .tx_line(tx_line), .tx_line_oe(tx_line_oe), .tx_irq(tx_irq),
    .rx_irq(rx_irq));
  remote_serial i_remote_serial (.clk(clk), .tx_line(tx_wire),
    .invert(inv), .nine(nine), .rx_line(rx_line));

  // A released pin floats up to its pull-up level.
  assign tx_wire = tx_line_oe ? tx_line : 1'b1;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short; the whole run needs far less than this.
  initial
  begin
    #600000;
    mismatches++;
    wrap_up();
  end

  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask

  // The extra idle cycle keeps two writes from touching wr in one step.
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask

  task automatic wait_irq(input bit on_rx);
    n = 0;
    while (((on_rx ? rx_irq : tx_irq) !== 1'b1) && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    check(n < 1000, 1'b1, "irq wait");
  endtask

  // Hands one character over the way software must, and notes its frame.
  task automatic send_tx(input logic [8:0] d);
    wait_irq(1'b0);
    if (nine)
      wreg(`OFS_CTRL_THREE, {1'b0, d[8], 6'h00});
    rreg(`OFS_STATUS_ONE, v);
    wreg(`OFS_DATA_BUF, d[7:0]);
    exp_q.push_back(nine ? 512 + d : 256 + d[7:0]);
  endtask

  task automatic wait_done();
    n = 0;
    v = 8'h00;
    while (v[`B_TX_DONE] !== 1'b1 && n < 400)
    begin
      rreg(`OFS_STATUS_ONE, v);
      n++;
    end
    check(n < 400, 1'b1, "done wait");
    repeat (16) @(posedge clk);
  endtask

  task automatic drain();
    check(i_remote_serial.got.size(), exp_q.size(), "frames");
    while (exp_q.size() > 0 && i_remote_serial.got.size() > 0)
      check(i_remote_serial.got.pop_front(), exp_q.pop_front(), "frame");
    check(tx_wire ^ inv, 1'b1, "idle line");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence: reset, transmit, receive, breaks, polarity, release.
  initial
  begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    inv = 1'b0;
    nine = 1'b0;
    seed = 32'h0b6181b7;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(tx_line_oe, 1'b0, "oe at reset");
    rreg(`OFS_STATUS_ONE, v);
    check(v, `RST_STATUS_ONE, "status reset");
    rreg(8'h00, v);
    check(v, 8'h00, "unmapped read");
    $display("reset test done");

    wreg(`OFS_CTRL_ONE, 8'h40);
    wreg(`OFS_CTRL_TWO, 8'hac);
    check({tx_line_oe, rx_line_used}, 2'b11, "pins owned");
    send_tx({1'b0, rnd8()});
    n = 0;
    while (tx_wire !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check(n >= 140 && n <= 175, 1'b1, "preamble");
    for (int k = 0; k < 3; k++)
      send_tx({1'b0, rnd8()});
    wait_done();
    drain();
    wreg(`OFS_CTRL_ONE, 8'h50);
    nine = 1'b1;
    for (int k = 0; k < 3; k++)
      send_tx({seed[20], rnd8()});
    wait_done();
    drain();
    $display("transmit test done");

    for (int m = 1; m >= 0; m--)
    begin
      nine = m[0];
      wreg(`OFS_CTRL_ONE, {3'b010, m[0], 4'h0});
      d9 = {seed[3], rnd8()};
      i_remote_serial.send_bits(m ? {2'b11, d9, 1'b0} :
        {3'b111, d9[7:0], 1'b0}, 12);
      wait_irq(1'b1);
      rreg(`OFS_STATUS_ONE, v);
      check(v, 8'he0, "rx status");
      rreg(`OFS_CTRL_THREE, v);
      check(v[7], m ? d9[8] : d9[7], "rx bit8");
      rreg(`OFS_DATA_BUF, v);
      check(v, d9[7:0], "rx data");
      check(rx_irq, 1'b0, "rx irq clear");
    end
    $display("receive test done");

    for (int t = 0; t < 5; t++)
    begin
      wreg(`OFS_BAUD_RATE, {1'b0, t >= 2, 6'h00});
      wreg(`OFS_CTRL_ONE, {3'b010, t[0], 4'h0});
      i_remote_serial.send_bits(12'h000, 10 + t[0] + (t == 2 || t == 3));
      wait_irq(1'b1);
      rreg(`OFS_STATUS_ONE, v);
      check(v | {6'h00, t == 4, 1'b0}, 8'he2, "brk status");
      rreg(`OFS_STATUS_TWO, v);
      check(v[1], t < 4, "brk flag");
      rreg(`OFS_CTRL_THREE, v);
      check(v[7], 1'b0, "brk bit8");
      rreg(`OFS_DATA_BUF, v);
      check(v, 8'h00, "brk data");
      repeat (48) @(posedge clk);
    end
    wreg(`OFS_BAUD_RATE, 8'h00);
    nine = 1'b0;
    $display("break receive test done");

    wreg(`OFS_CTRL_TWO, 8'had);
    repeat (320) @(posedge clk);
    check(tx_line, 1'b0, "break level");
    wreg(`OFS_CTRL_TWO, 8'hac);
    n = 0;
    while (tx_line !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    repeat (15) @(posedge clk);
    check(tx_line, 1'b1, "one after break");
    exp_q.push_back(0);
    wait_done();
    drain();
    $display("break send test done");

    wreg(`OFS_CTRL_ONE, 8'h60);
    inv = 1'b1;
    repeat (2) @(posedge clk);
    check(tx_line, 1'b0, "inverted idle");
    send_tx({1'b0, rnd8()});
    repeat (40) @(posedge clk);
    wreg(`OFS_CTRL_TWO, 8'ha4);
    wreg(`OFS_CTRL_TWO, 8'hac);
    send_tx({1'b0, rnd8()});
    wait_done();
    drain();
    send_tx({1'b0, rnd8()});
    repeat (40) @(posedge clk);
    wreg(`OFS_CTRL_TWO, 8'ha4);
    repeat (200) @(posedge clk);
    drain();
    wreg(`OFS_CTRL_ONE, 8'h00);
    check({tx_line_oe, rx_line_used}, 2'b00, "pins freed");
    $display("polarity and release test done");
    wrap_up();
  end
endmodule
